//--- eeic_consts.svh
// Offsets, field layouts, reset values and widths of the edge interrupt block
`ifndef EEIC_CONSTS_SVH
`define EEIC_CONSTS_SVH
`define EEIC_LINES 16
`define EEIC_AW 4
`define EEIC_PORT_PINS 64
`define EEIC_SEL_W 6
`define EEIC_OFF_IMR 4'h0
`define EEIC_OFF_EMR 4'h1
`define EEIC_OFF_RTSR 4'h2
`define EEIC_OFF_FTSR 4'h3
`define EEIC_OFF_SWIER 4'h4
`define EEIC_OFF_PR 4'h5
`define EEIC_OFF_MASK 4'h6
`define EEIC_OFF_STAT 4'h7
`define EEIC_OFF_SEL0 4'h8
`define EEIC_OFF_SEL1 4'h9
`define EEIC_OFF_SEL2 4'hA
`define EEIC_OFF_SEL3 4'hB
`define EEIC_OFF_LEVEL 4'hC
`define EEIC_RST_ZERO 16'h0000
`define EEIC_SEL_PER_REG 4
`define EEIC_SEL_FIELD_W 8
`define EEIC_STAT_IRQ_BIT 0
`define EEIC_STAT_EVT_BIT 1
`define EEIC_STAT_WAKE_BIT 2
`define EEIC_STAT_W 3
`endif

//--- eeic_edge_catch.sv
// Asynchronous edge catcher with synchroniser for one line
`timescale 1ns/1ps
`default_nettype none
module eeic_edge_catch (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic line_in,
  input wire logic rise_en,
  input wire logic fall_en,
  input wire logic ack,
  output logic edge_seen
);
  logic rise_lat;
  logic fall_lat;
  logic clr_r;
  logic clr_f;
  logic [2:0] sync_ff;
  // Pulse shorter than one clock still sets the latch
  assign clr_r = sys_rst | ack | ~rise_en;
  assign clr_f = sys_rst | ack | ~fall_en;
  always_ff @(posedge line_in or posedge clr_r) begin
    if (clr_r) begin
      rise_lat <= 1'b0;
    end else begin
      rise_lat <= 1'b1;
    end
  end
  always_ff @(negedge line_in or posedge clr_f) begin
    if (clr_f) begin
      fall_lat <= 1'b0;
    end else begin
      fall_lat <= 1'b1;
    end
  end
  // Two-stage synchroniser, third stage for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], rise_lat | fall_lat};
    end
  end
  assign edge_seen = sync_ff[1] & ~sync_ff[2];
endmodule
`default_nettype wire

//--- eeic_pin_model.sv
// Port pin and interrupt receiver model for the edge interrupt bench
`timescale 1ns/1ps
`default_nettype none
`include "eeic_consts.svh"
module eeic_pin_model (
  input wire logic clk,
  input wire logic irq,
  output logic [`EEIC_PORT_PINS-1:0] pins,
  output logic [7:0] irq_count
);
  // ****************************************
  // Pin drive and request counting
  // ****************************************
  initial begin
    pins = '0;
    irq_count = 8'h00;
  end
  // One full edge on a pin, launched at a rising clock edge
  task automatic toggle(input int p);
    @(posedge clk);
    pins[p] <= ~pins[p];
  endtask
  // Pulse far shorter than a clock period, placed between edges
  task automatic short_pulse(input int p);
    @(negedge clk);
    pins[p] = 1'b1;
    #5;
    pins[p] = 1'b0;
  endtask
  always @(posedge irq) begin
    irq_count <= irq_count + 8'h01;
  end
endmodule
`default_nettype wire

//--- eeic_pkg.sv
// Types shared by the edge interrupt block
package eeic_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } eeic_bus_req_t;
  typedef struct packed {
    logic irq;
    logic evt;
    logic wake;
  } eeic_out_t;
  typedef enum logic [1:0] {
    EEIC_ST_RUN = 2'b01,
    EEIC_ST_STOP = 2'b10
  } eeic_mode_t;
endpackage

//--- eeic_top.sv
// External edge interrupt controller top with register port
`timescale 1ns/1ps
`default_nettype none
`include "eeic_consts.svh"
// Operation
// (R1) Sixteen lines, each routed from any port pin
// (R2) Per-line enable; disabled lines raise nothing
// (R3) Rising, falling or both edges per line
// (R4) Pending bits latched, readable together
// (R5) Enabled edges raise interrupt or event
// (R6) Pulses shorter than a clock are caught
// (R7) Detection continues in stop mode, wakes system
// (R8) Write one clears; request held while pending
module eeic_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`EEIC_PORT_PINS-1:0] port_pins,
  input wire logic supply_voltage_monitor,
  input wire logic stop_mode,
  input wire eeic_pkg::eeic_bus_req_t bus,
  output logic [31:0] rdata,
  output logic irq,
  output logic evt,
  output logic wake,
  output logic [`EEIC_LINES-1:0] evt_lines
);
  import eeic_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] imr;
    logic [15:0] emr;
    logic [15:0] rtsr;
    logic [15:0] ftsr;
    logic [15:0] pr;
    logic [2:0] mask;
    logic [2:0] stat;
    logic [3:0][7:0] sel0;
    logic [3:0][7:0] sel1;
    logic [3:0][7:0] sel2;
    logic [3:0][7:0] sel3;
    logic pvd_d;
    eeic_mode_t mode;
    logic [31:0] rdata;
    logic irq;
    logic evt;
    logic wake;
    logic [15:0] evt_lines;
  } eeic_state_t;
  eeic_state_t st_ff;
  eeic_state_t nxt_st;

  logic [`EEIC_LINES-1:0] line_sig;
  logic [`EEIC_LINES-1:0] edge_hit;
  logic [`EEIC_LINES-1:0] ack;
  logic [`EEIC_LINES-1:0] any_en;
  logic [127:0] sel_flat;

  function automatic logic [`EEIC_SEL_W-1:0] sel_of(input logic [127:0] f, input int i);
    sel_of = f[i*`EEIC_SEL_FIELD_W +: `EEIC_SEL_W];
  endfunction

  function automatic logic hit_wr(input eeic_bus_req_t b, input logic [3:0] off);
    hit_wr = b.wr && (b.addr == off);
  endfunction

  // ****************************************
  // Line routing and edge capture
  // ****************************************
  assign sel_flat = {st_ff.sel3, st_ff.sel2, st_ff.sel1, st_ff.sel0};
  assign any_en = st_ff.imr | st_ff.emr;

  genvar g;
  generate
    for (g = 0; g < `EEIC_LINES; g++) begin : g_line
      assign line_sig[g] = port_pins[sel_of(sel_flat, g)]; // R1
      assign ack[g] = edge_hit[g];
      eeic_edge_catch u_catch (
        .clk(clk),
        .sys_rst(sys_rst),
        .line_in(line_sig[g]),
        .rise_en(st_ff.rtsr[g] & any_en[g]), // R3 R2 R6
        .fall_en(st_ff.ftsr[g] & any_en[g]), // R3 R2 R6
        .ack(ack[g]),
        .edge_seen(edge_hit[g])
      );
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [15:0] swi;
    logic [15:0] pr_set;
    logic [15:0] pr_clr;
    logic pvd_edge;
    logic [2:0] ev;
    nxt_st = st_ff;
    pr_set = 16'h0000;
    ev = 3'h0;
    swi = 16'h0000;
    pr_clr = 16'h0000;
    pvd_edge = supply_voltage_monitor & ~st_ff.pvd_d;
    if (hit_wr(bus, `EEIC_OFF_SWIER)) begin
      swi = bus.wdata[15:0];
    end
    if (hit_wr(bus, `EEIC_OFF_PR)) begin
      pr_clr = bus.wdata[15:0];
    end
    pr_set = (edge_hit | swi) & st_ff.imr; // R2 R4
    nxt_st.pr = (st_ff.pr & ~pr_clr) | pr_set; // R8 R4
    nxt_st.evt_lines = (edge_hit | swi) & st_ff.emr; // R5
    nxt_st.pvd_d = supply_voltage_monitor;
    if (hit_wr(bus, `EEIC_OFF_IMR)) nxt_st.imr = bus.wdata[15:0];
    if (hit_wr(bus, `EEIC_OFF_EMR)) nxt_st.emr = bus.wdata[15:0];
    if (hit_wr(bus, `EEIC_OFF_RTSR)) nxt_st.rtsr = bus.wdata[15:0];
    if (hit_wr(bus, `EEIC_OFF_FTSR)) nxt_st.ftsr = bus.wdata[15:0];
    if (hit_wr(bus, `EEIC_OFF_MASK)) nxt_st.mask = bus.wdata[2:0];
    if (hit_wr(bus, `EEIC_OFF_SEL0)) nxt_st.sel0 = bus.wdata;
    if (hit_wr(bus, `EEIC_OFF_SEL1)) nxt_st.sel1 = bus.wdata;
    if (hit_wr(bus, `EEIC_OFF_SEL2)) nxt_st.sel2 = bus.wdata;
    if (hit_wr(bus, `EEIC_OFF_SEL3)) nxt_st.sel3 = bus.wdata;
    // Mode tracking; edges keep being caught in stop
    case (st_ff.mode)
      EEIC_ST_RUN: if (stop_mode) nxt_st.mode = EEIC_ST_STOP;
      EEIC_ST_STOP: if (!stop_mode) nxt_st.mode = EEIC_ST_RUN;
      default: nxt_st.mode = EEIC_ST_RUN;
    endcase
    ev[`EEIC_STAT_IRQ_BIT] = |pr_set;
    ev[`EEIC_STAT_EVT_BIT] = |nxt_st.evt_lines;
    ev[`EEIC_STAT_WAKE_BIT] = (st_ff.mode == EEIC_ST_STOP) && ((|nxt_st.evt_lines) || (|pr_set) || pvd_edge);
    nxt_st.stat = st_ff.stat;
    if (hit_wr(bus, `EEIC_OFF_STAT)) nxt_st.stat = st_ff.stat & ~bus.wdata[2:0];
    nxt_st.stat = nxt_st.stat | ev;
    nxt_st.irq = (|(nxt_st.pr & nxt_st.imr)) | (|(nxt_st.stat & nxt_st.mask)); // R5 R8
    nxt_st.evt = |nxt_st.evt_lines; // R5
    nxt_st.wake = (nxt_st.mode == EEIC_ST_STOP) && ((|nxt_st.pr) || ev[`EEIC_STAT_WAKE_BIT]); // R7
    nxt_st.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        `EEIC_OFF_IMR: nxt_st.rdata = {16'h0000, st_ff.imr};
        `EEIC_OFF_EMR: nxt_st.rdata = {16'h0000, st_ff.emr};
        `EEIC_OFF_RTSR: nxt_st.rdata = {16'h0000, st_ff.rtsr};
        `EEIC_OFF_FTSR: nxt_st.rdata = {16'h0000, st_ff.ftsr};
        `EEIC_OFF_PR: nxt_st.rdata = {16'h0000, st_ff.pr}; // R4
        `EEIC_OFF_MASK: nxt_st.rdata = {29'h0, st_ff.mask};
        `EEIC_OFF_STAT: nxt_st.rdata = {29'h0, st_ff.stat};
        `EEIC_OFF_SEL0: nxt_st.rdata = st_ff.sel0;
        `EEIC_OFF_SEL1: nxt_st.rdata = st_ff.sel1;
        `EEIC_OFF_SEL2: nxt_st.rdata = st_ff.sel2;
        `EEIC_OFF_SEL3: nxt_st.rdata = st_ff.sel3;
        `EEIC_OFF_LEVEL: nxt_st.rdata = {16'h0000, line_sig};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.mode <= EEIC_ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata = st_ff.rdata;
  assign irq = st_ff.irq;
  assign evt = st_ff.evt;
  assign wake = st_ff.wake;
  assign evt_lines = st_ff.evt_lines;

  // ****************************************
  // Assertions
  // ****************************************
  property p_pend_hold;
    @(posedge clk) disable iff (sys_rst)
      (|st_ff.pr) && !hit_wr(bus, `EEIC_OFF_PR) |=> (|st_ff.pr);
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending dropped without clear"); // R8

  property p_irq_follows;
    @(posedge clk) disable iff (sys_rst)
      (|(st_ff.pr & st_ff.imr)) |-> st_ff.irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq low with pending"); // R8

  property p_disabled_no_pend;
    @(posedge clk) disable iff (sys_rst)
      (!st_ff.imr[0] && !$past(st_ff.imr[0]) && !st_ff.pr[0]) |=> !st_ff.pr[0];
  endproperty
  a_disabled_no_pend: assert property (p_disabled_no_pend) else $error("disabled line pended"); // R2

  property p_edge_pends;
    @(posedge clk) disable iff (sys_rst)
      (edge_hit[0] && st_ff.imr[0]) |=> st_ff.pr[0];
  endproperty
  a_edge_pends: assert property (p_edge_pends) else $error("edge not pended"); // R4

  property p_evt_out;
    @(posedge clk) disable iff (sys_rst)
      (|(edge_hit & st_ff.emr)) |=> evt;
  endproperty
  a_evt_out: assert property (p_evt_out) else $error("event missing"); // R5

  property p_pr_read;
    @(posedge clk) disable iff (sys_rst)
      (bus.rd && bus.addr == `EEIC_OFF_PR) |=> (rdata[15:0] == $past(st_ff.pr));
  endproperty
  a_pr_read: assert property (p_pr_read) else $error("pending read wrong"); // R4

  property p_wake;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.mode == EEIC_ST_STOP && stop_mode && (|st_ff.pr) && !hit_wr(bus, `EEIC_OFF_PR)) |=> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake in stop"); // R7

  property p_stat_irq;
    @(posedge clk) disable iff (sys_rst)
      (|(st_ff.stat & st_ff.mask)) |-> irq;
  endproperty
  a_stat_irq: assert property (p_stat_irq) else $error("masked status without irq"); // R5

  property p_rdata_idle;
    @(posedge clk) disable iff (sys_rst)
      !bus.rd |=> (rdata == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read"); // R4

  property p_stat_sticky;
    @(posedge clk) disable iff (sys_rst)
      !hit_wr(bus, `EEIC_OFF_STAT) |=> ((st_ff.stat & $past(st_ff.stat)) == $past(st_ff.stat));
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost"); // R8

  property p_evt_disabled;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.emr == 16'h0000) |=> (evt_lines == 16'h0000);
  endproperty
  a_evt_disabled: assert property (p_evt_disabled) else $error("event on disabled line"); // R2

  property p_no_enable_no_pend;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.imr == 16'h0000 && st_ff.pr == 16'h0000) |=> (st_ff.pr == 16'h0000);
  endproperty
  a_no_enable_no_pend: assert property (p_no_enable_no_pend) else $error("pending with no enable"); // R2

  property p_evt_pulse;
    @(posedge clk) disable iff (sys_rst)
      evt |-> (|evt_lines);
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("event without line"); // R5

  property p_run_no_wake;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.mode == EEIC_ST_RUN && !stop_mode) |=> !wake;
  endproperty
  a_run_no_wake: assert property (p_run_no_wake) else $error("wake outside stop"); // R7

  sequence s_stop_req;
    st_ff.mode == EEIC_ST_RUN && stop_mode;
  endsequence
  property p_stop_enter;
    @(posedge clk) disable iff (sys_rst)
      s_stop_req |=> (st_ff.mode == EEIC_ST_STOP);
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered"); // R7

  property p_swi_pend;
    @(posedge clk) disable iff (sys_rst)
      (hit_wr(bus, `EEIC_OFF_SWIER) && (|(bus.wdata[15:0] & st_ff.imr))) |=> (|st_ff.pr);
  endproperty
  a_swi_pend: assert property (p_swi_pend) else $error("soft trigger not pended"); // R4

  property p_level_read;
    @(posedge clk) disable iff (sys_rst)
      (bus.rd && bus.addr == `EEIC_OFF_LEVEL) |=> (rdata[15:0] == $past(line_sig));
  endproperty
  a_level_read: assert property (p_level_read) else $error("line level read wrong"); // R1

  property p_clr_line0;
    @(posedge clk) disable iff (sys_rst)
      (hit_wr(bus, `EEIC_OFF_PR) && bus.wdata[0] && !edge_hit[0]) |=> !st_ff.pr[0];
  endproperty
  a_clr_line0: assert property (p_clr_line0) else $error("line pending not cleared"); // R8

  property p_wake_source;
    @(posedge clk) disable iff (sys_rst)
      (st_ff.mode == EEIC_ST_STOP && stop_mode && supply_voltage_monitor && !st_ff.pvd_d)
        |=> st_ff.stat[`EEIC_STAT_WAKE_BIT];
  endproperty
  a_wake_source: assert property (p_wake_source) else $error("monitor wake not seen"); // R7

  sequence s_pend_clear;
    bus.wr && bus.addr == `EEIC_OFF_PR && (&bus.wdata[15:0]) && !(|edge_hit);
  endsequence
  property p_clear;
    @(posedge clk) disable iff (sys_rst)
      s_pend_clear |=> (st_ff.pr == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear"); // R8
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the external edge interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "eeic_consts.svh"
module tb;
  import eeic_pkg::*;
  // ****************************************
  // Clock, design and pin model
  // ****************************************
  localparam int PIN_OFS = 40;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic stop_mode = 1'b0;
  logic svm = 1'b0;
  eeic_bus_req_t bus = '0;
  logic [31:0] rdata;
  logic irq, evt, wake;
  logic [15:0] evt_lines;
  logic [63:0] pins;
  logic [7:0] irq_count;
  int fails = 0;
  int samples_checked = 0;
  int seed = 32'h519FDE68;
  logic [15:0] evt_acc = 16'h0000;
  int evt_cnt = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    evt_acc <= evt_acc | evt_lines;
    if (evt) begin
      evt_cnt <= evt_cnt + 1;
    end
  end
  eeic_top eeic_top_inst (.clk(clk), .sys_rst(sys_rst), .port_pins(pins), .supply_voltage_monitor(svm),
    .stop_mode(stop_mode), .bus(bus), .rdata(rdata), .irq(irq), .evt(evt), .wake(wake), .evt_lines(evt_lines));
  eeic_pin_model eeic_pin_model_inst (.clk(clk), .irq(irq), .pins(pins), .irq_count(irq_count));
  // ****************************************
  // Bus tasks, checks and expectations
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic hit(input logic en, input logic rise, input logic fall, input logic up);
    return en & (up ? rise : fall);
  endfunction
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] v, d, m;
    logic en, ri, fa, up, h;
    int ln, mode, nhit;
    nhit = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`EEIC_OFF_PR, v);
    check(v, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
    rd(4'hD, v);
    check(v, 32'h00000000);
    $display("Test reset done");
    for (int r = 0; r < 4; r++) begin
      d = 32'h00000000;
      for (int k = 0; k < 4; k++) begin
        d[k*8 +: 8] = 8'(r * 4 + k + PIN_OFS);
      end
      wr(`EEIC_OFF_SEL0 + 4'(r), d);
    end
    eeic_pin_model_inst.toggle(PIN_OFS + 5);
    rd(`EEIC_OFF_LEVEL, v);
    check(v, {16'h0000, pins[PIN_OFS +: 16]});
    $display("Test routing done");
    for (int i = 0; i < 24; i++) begin
      ln = $random(seed) & 15;
      mode = $random(seed) & 3;
      en = (mode != 0);
      ri = (mode != 2);
      fa = (mode != 1);
      m = 32'h00000001 << ln;
      wr(`EEIC_OFF_IMR, en ? m : 32'h00000000);
      wr(`EEIC_OFF_RTSR, ri ? m : 32'h00000000);
      wr(`EEIC_OFF_FTSR, fa ? m : 32'h00000000);
      up = ~pins[PIN_OFS + ln];
      eeic_pin_model_inst.toggle(PIN_OFS + ln);
      h = hit(en, ri, fa, up);
      if (h) begin
        nhit++;
      end
      repeat (6) @(posedge clk);
      rd(`EEIC_OFF_PR, v);
      check(v, h ? m : 32'h00000000);
      check({31'h0, irq}, {31'h0, h});
      wr(`EEIC_OFF_PR, 32'h0000FFFF);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, 32'h00000000);
    end
    check({24'h000000, irq_count}, 32'(nhit));
    $display("Test edge modes done");
    wr(`EEIC_OFF_IMR, 32'h00000000);
    wr(`EEIC_OFF_EMR, 32'h00000020);
    wr(`EEIC_OFF_RTSR, 32'h00000020);
    wr(`EEIC_OFF_FTSR, 32'h00000020);
    eeic_pin_model_inst.toggle(PIN_OFS + 5);
    repeat (6) @(posedge clk);
    check({16'h0000, evt_acc}, 32'h00000020);
    check(32'(evt_cnt), 32'h00000001);
    rd(`EEIC_OFF_STAT, v);
    check(v & 32'h00000002, 32'h00000002);
    wr(`EEIC_OFF_EMR, 32'h00000000);
    $display("Test events done");
    wr(`EEIC_OFF_IMR, 32'h00000008);
    wr(`EEIC_OFF_RTSR, 32'h00000008);
    if (pins[PIN_OFS + 3]) begin
      eeic_pin_model_inst.toggle(PIN_OFS + 3);
    end
    repeat (6) @(posedge clk);
    wr(`EEIC_OFF_PR, 32'h0000FFFF);
    eeic_pin_model_inst.short_pulse(PIN_OFS + 3);
    repeat (6) @(posedge clk);
    rd(`EEIC_OFF_PR, v);
    check(v, 32'h00000008);
    $display("Test short pulse done");
    stop_mode <= 1'b1;
    repeat (4) @(posedge clk);
    check({31'h0, wake}, 32'h00000001);
    wr(`EEIC_OFF_PR, 32'h0000FFFF);
    wr(`EEIC_OFF_STAT, 32'h00000007);
    svm <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`EEIC_OFF_STAT, v);
    check(v, 32'h00000004);
    svm <= 1'b0;
    stop_mode <= 1'b0;
    $display("Test stop wake done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
